// *** shared/pattern_ctrl_pkg.sv ***
package pattern_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RAM_DEPTH = 128;
   localparam int RAM_AW = 7;
   localparam logic [7:0] PATTERN_RAM_LAST = 8'h7F;
   localparam logic [7:0] FUNCTION_ENABLE_ADDR = 8'h80;
   localparam logic [7:0] SHARED_FIRST = 8'hA0;
   localparam logic [7:0] SHARED_LAST = 8'hAF;
   localparam logic [7:0] SHARED_CONTROL_SLOT_A_ADDR = 8'hAA;
   localparam logic [7:0] SHARED_CONTROL_SLOT_B_ADDR = 8'hAB;
   localparam logic [7:0] GESTURE_FIFO_LEVEL_ADDR = 8'hAE;
   localparam logic [7:0] GESTURE_STATE_FLAGS_ADDR = 8'hAF;
   localparam logic [7:0] SYMBOL_LENGTH_ADDR = 8'hA7;
   localparam logic [7:0] BIT_TIME_ADDR = 8'hA6;
   localparam logic [7:0] BURST_IRQ_CLEAR_ADDR = 8'hE3;
   localparam logic [7:0] IRQ_FORCE_ADDR = 8'hE4;
   localparam logic [7:0] PROXIMITY_IRQ_CLEAR_ADDR = 8'hE5;
   localparam logic [7:0] LIGHT_IRQ_CLEAR_ADDR = 8'hE6;
   localparam logic [7:0] ALL_IRQ_CLEAR_ADDR = 8'hE7;
   localparam logic [7:0] GESTURE_NORTH_QUEUE_ADDR = 8'hFC;
   localparam logic [7:0] GESTURE_SOUTH_QUEUE_ADDR = 8'hFD;
   localparam logic [7:0] GESTURE_WEST_QUEUE_ADDR = 8'hFE;
   localparam logic [7:0] GESTURE_EAST_QUEUE_ADDR = 8'hFF;
   localparam logic [7:0] FUNCTION_ENABLE_RESET = 8'h00;
   localparam logic [7:0] SHARED_RESET = 8'h00;
   localparam int EN_POWER = 0;
   localparam int EN_LIGHT = 1;
   localparam int EN_PROX = 2;
   localparam int EN_WAIT = 3;
   localparam int EN_LIGHT_IRQ = 4;
   localparam int EN_PROX_IRQ = 5;
   localparam int EN_GESTURE = 6;
   localparam int EN_BURST = 7;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   typedef enum logic [1:0] {burst_idle, burst_fetch, burst_shift} burst_state_t;
endpackage

// *** verilog/pattern_mem.sv ***
module pattern_mem
   import pattern_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [pattern_ctrl_pkg::RAM_AW-1:0] wr_addr,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] wr_data,
   input wire logic [pattern_ctrl_pkg::RAM_AW-1:0] rd_addr,
   output logic [pattern_ctrl_pkg::DATA_W-1:0] rd_data
);
   // no reset: contents live as long as supply does
   logic [DATA_W-1:0] mem [RAM_DEPTH]; // RULE7

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // pattern_mem

// *** verilog/pattern_ctrl.sv ***
// Behaviour
// RULE1 - one shared buffer serves every engine
// RULE2 - host zeroes unused shared locations
// RULE3 - 128 pattern bytes drive LED pin
// RULE4 - burst MSB first from address zero
// RULE5 - single or sequential pattern accesses
// RULE6 - no pattern access unpowered or busy
// RULE7 - pattern contents survive power bit
// RULE8 - gesture enable overwrites pattern storage
// RULE9 - upper nibble first, bit 7 down
// RULE10 - burst enable hands pin to burst
// RULE11 - burst enable blocks proximity pulses
// RULE12 - gesture start needs enable, prox, mode
// RULE13 - proximity irq enable gates prox irq
// RULE14 - light irq enable gates light irq
// RULE15 - wait enable bit runs wait timer
// RULE16 - proximity enable bit runs proximity
// RULE17 - light enable bit runs ambient light
// RULE18 - power bit runs oscillator
// RULE19 - bus activity forces oscillator on
// RULE20 - host programs controls before enabling
// RULE21 - one location clears non-gesture irqs
// RULE22 - one location clears burst irq
// RULE23 - enable register resets to zero
// RULE24 - symbol length write starts burst
module pattern_ctrl
   import pattern_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic bus_active,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [pattern_ctrl_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] reg_wdata,
   output logic [pattern_ctrl_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic gesture_mode_select,
   input wire logic prox_pulse,
   input wire logic prox_irq_event,
   input wire logic light_irq_event,
   input wire logic gesture_wr,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] gesture_data,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] gesture_queue_n,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] gesture_queue_s,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] gesture_queue_w,
   input wire logic [pattern_ctrl_pkg::DATA_W-1:0] gesture_queue_e,
   output logic led_drive_pin,
   output logic pattern_busy_flag,
   output logic oscillator_run,
   output logic wait_timer_run,
   output logic proximity_run,
   output logic light_run,
   output logic gesture_start,
   output logic prox_irq,
   output logic light_irq,
   output logic burst_irq,
   output logic irq_force_pulse
);
   import pattern_ctrl_pkg::*;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] function_enable_r;
   logic [7:0] shared_r [16];
   logic [7:0] gesture_wptr_r;
   burst_state_t state_r;
   logic [6:0] byte_addr_r;
   logic [2:0] bit_idx_r;
   logic [7:0] nib_cnt_r;
   logic [7:0] nib_len_r;
   logic [7:0] bit_time_cnt_r;
   logic [7:0] shift_byte_r;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic en_power = function_enable_r[EN_POWER];
   wire logic busy = (state_r != burst_idle);
   wire logic hit_ram = (reg_addr <= PATTERN_RAM_LAST);
   wire logic ram_open = en_power && !busy; // RULE6
   wire logic hit_enable = (reg_addr == FUNCTION_ENABLE_ADDR);
   wire logic hit_shared = in_range(reg_addr, SHARED_FIRST, SHARED_LAST);
   wire logic [3:0] shared_idx = reg_addr[3:0];
   wire logic start_burst = reg_wr && (reg_addr == SYMBOL_LENGTH_ADDR) && en_power
                            && !busy; // RULE24
   wire logic clr_burst = (reg_wr || reg_rd)
                          && ((reg_addr == BURST_IRQ_CLEAR_ADDR)
                          || (reg_addr == ALL_IRQ_CLEAR_ADDR)); // RULE22
   wire logic clr_prox = (reg_wr || reg_rd)
                         && ((reg_addr == PROXIMITY_IRQ_CLEAR_ADDR)
                         || (reg_addr == ALL_IRQ_CLEAR_ADDR)); // RULE21
   wire logic clr_light = (reg_wr || reg_rd)
                          && ((reg_addr == LIGHT_IRQ_CLEAR_ADDR)
                          || (reg_addr == ALL_IRQ_CLEAR_ADDR)); // RULE21
   wire logic force_hit = reg_wr && (reg_addr == IRQ_FORCE_ADDR);
   wire logic gesture_on = function_enable_r[EN_GESTURE];
   wire logic gest_store = gesture_on && gesture_wr; // RULE8
   wire logic host_ram_wr = reg_wr && hit_ram && ram_open && !gesture_on; // RULE5
   wire logic mem_wr = gest_store || host_ram_wr;
   wire logic [6:0] mem_waddr = gest_store ? gesture_wptr_r[6:0] : reg_addr[6:0];
   wire logic [7:0] mem_wdata = gest_store ? gesture_data : reg_wdata;
   // the memory answers a cycle late, so the burst presents the next byte ahead of the fetch
   wire logic [6:0] mem_raddr = start_burst ? 7'h00
                                : busy ? 7'(byte_addr_r + 7'h01) : reg_addr[6:0]; // RULE4
   wire logic [7:0] mem_rdata;
   wire logic bit_done = (bit_time_cnt_r == 8'h00);
   wire logic last_bit = (bit_idx_r == 3'h0) || (bit_idx_r == 3'h4);
   wire logic last_nib = (nib_cnt_r == nib_len_r);
   wire logic [7:0] bit_time = shared_r[BIT_TIME_ADDR[3:0]];

   ////////////////////////////////////////////////////////////////////////////
   // pattern storage, shared with the gesture queue writer
   pattern_mem u_mem (
      .core_clk(core_clk),
      .wr_en(mem_wr),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // enable and shared buffer
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         function_enable_r <= FUNCTION_ENABLE_RESET; // RULE23
      end else if (reg_wr && hit_enable) begin
         function_enable_r <= reg_wdata; // RULE15
      end
   end

   // a single array answers every engine, so leftovers are visible to all
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++) begin
            shared_r[i] <= SHARED_RESET;
         end
      end else if (reg_wr && hit_shared) begin
         shared_r[shared_idx] <= reg_wdata; // RULE1
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         gesture_wptr_r <= 8'h00;
      end else if (!gesture_on) begin
         gesture_wptr_r <= 8'h00;
      end else if (gest_store) begin
         gesture_wptr_r <= 8'((gesture_wptr_r + 8'h01) & 8'h7F);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // burst engine
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_r <= burst_idle;
         byte_addr_r <= 7'h00;
         bit_idx_r <= 3'h7;
         nib_cnt_r <= 8'h00;
         nib_len_r <= 8'h00;
         bit_time_cnt_r <= 8'h00;
         shift_byte_r <= 8'h00;
      end else begin
         case (state_r)
            burst_idle: begin
               if (start_burst) begin
                  state_r <= burst_fetch;
                  byte_addr_r <= 7'h00; // RULE4
                  nib_cnt_r <= 8'h00;
                  nib_len_r <= reg_wdata;
               end
            end
            burst_fetch: begin
               // one cycle for the registered memory read
               state_r <= burst_shift;
               shift_byte_r <= mem_rdata;
               bit_idx_r <= 3'h7; // RULE9
               bit_time_cnt_r <= bit_time;
            end
            burst_shift: begin
               if (!en_power) begin
                  state_r <= burst_idle;
               end else if (bit_done) begin
                  bit_time_cnt_r <= bit_time;
                  if (last_bit && last_nib) begin
                     state_r <= burst_idle;
                  end else if (bit_idx_r == 3'h0) begin
                     nib_cnt_r <= 8'(nib_cnt_r + 8'h01);
                     byte_addr_r <= 7'(byte_addr_r + 7'h01);
                     state_r <= burst_fetch;
                  end else begin
                     if (last_bit) begin
                        nib_cnt_r <= 8'(nib_cnt_r + 8'h01);
                     end
                     bit_idx_r <= 3'(bit_idx_r - 3'h1); // RULE9
                  end
               end else begin
                  bit_time_cnt_r <= 8'(bit_time_cnt_r - 8'h01);
               end
            end
            default: state_r <= burst_idle;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data mux: ram reads are one cycle late, so every read answers late
   logic rd_ram_q;
   logic [7:0] rd_other_q;
   logic [7:0] other_mux;
   always_comb begin
      other_mux = UNMAPPED_READ;
      if (hit_enable) begin
         other_mux = function_enable_r;
      end else if (hit_shared) begin
         other_mux = shared_r[shared_idx];
      end else if (reg_addr == GESTURE_NORTH_QUEUE_ADDR) begin
         other_mux = gesture_queue_n;
      end else if (reg_addr == GESTURE_SOUTH_QUEUE_ADDR) begin
         other_mux = gesture_queue_s;
      end else if (reg_addr == GESTURE_WEST_QUEUE_ADDR) begin
         other_mux = gesture_queue_w;
      end else if (reg_addr == GESTURE_EAST_QUEUE_ADDR) begin
         other_mux = gesture_queue_e;
      end
   end

   logic rd_q;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rd_q <= 1'b0;
         rd_ram_q <= 1'b0;
         rd_other_q <= 8'h00;
      end else begin
         rd_q <= reg_rd;
         rd_ram_q <= reg_rd && hit_ram && ram_open; // RULE6
         rd_other_q <= hit_ram ? UNMAPPED_READ : other_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   logic burst_end;
   assign burst_end = (state_r == burst_shift) && bit_done && last_bit && last_nib;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         led_drive_pin <= 1'b0;
         pattern_busy_flag <= 1'b0;
         oscillator_run <= 1'b0;
         wait_timer_run <= 1'b0;
         proximity_run <= 1'b0;
         light_run <= 1'b0;
         gesture_start <= 1'b0;
         prox_irq <= 1'b0;
         light_irq <= 1'b0;
         burst_irq <= 1'b0;
         irq_force_pulse <= 1'b0;
      end else begin
         reg_rvalid <= rd_q;
         reg_rdata <= rd_ram_q ? mem_rdata : rd_other_q;
         if (function_enable_r[EN_BURST]) begin
            // proximity pulses never reach the pin here
            led_drive_pin <= (state_r == burst_shift) && shift_byte_r[bit_idx_r]; // RULE10 RULE11 RULE3
         end else begin
            led_drive_pin <= prox_pulse;
         end
         pattern_busy_flag <= start_burst || (busy && !burst_end && en_power); // RULE24
         oscillator_run <= en_power || bus_active; // RULE18 RULE19
         wait_timer_run <= function_enable_r[EN_WAIT]; // RULE15
         proximity_run <= function_enable_r[EN_PROX]; // RULE16
         light_run <= function_enable_r[EN_LIGHT]; // RULE17
         gesture_start <= gesture_on && function_enable_r[EN_PROX]
                          && gesture_mode_select; // RULE12
         // set beats clear when both land together
         prox_irq <= (prox_irq_event && function_enable_r[EN_PROX_IRQ])
                     || (prox_irq && !clr_prox); // RULE13 RULE21
         light_irq <= (light_irq_event && function_enable_r[EN_LIGHT_IRQ])
                      || (light_irq && !clr_light); // RULE14 RULE21
         burst_irq <= burst_end || (burst_irq && !clr_burst); // RULE22
         irq_force_pulse <= force_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_enable_reset: assert property (@(posedge core_clk)
      !resetn |=> function_enable_r == 8'h00) // RULE23
      else $error("enable not cleared by reset");
   chk_osc_bus: assert property (@(posedge core_clk) disable iff (!resetn)
      bus_active |=> oscillator_run) // RULE19
      else $error("oscillator off during bus activity");
   chk_osc_power: assert property (@(posedge core_clk) disable iff (!resetn)
      !bus_active && !en_power |=> !oscillator_run) // RULE18
      else $error("oscillator runs while powered down");
   chk_busy_start: assert property (@(posedge core_clk) disable iff (!resetn)
      start_burst |=> pattern_busy_flag && state_r == burst_fetch) // RULE24
      else $error("burst did not start");
   chk_prox_blocked: assert property (@(posedge core_clk) disable iff (!resetn)
      function_enable_r[EN_BURST] && state_r == burst_idle |=> !led_drive_pin) // RULE11
      else $error("proximity pulse leaked to pin");
   chk_ram_locked: assert property (@(posedge core_clk) disable iff (!resetn)
      host_ram_wr |-> en_power && !busy) // RULE6
      else $error("pattern written while locked");
   chk_ram_refused: assert property (@(posedge core_clk) disable iff (!resetn)
      reg_rd && hit_ram && !ram_open |=> ##1 reg_rdata == UNMAPPED_READ) // RULE6
      else $error("locked pattern read returned data");
   chk_first_addr: assert property (@(posedge core_clk) disable iff (!resetn)
      start_burst |=> byte_addr_r == 7'h00) // RULE4
      else $error("burst not from address zero");
   chk_msb_first: assert property (@(posedge core_clk) disable iff (!resetn)
      state_r == burst_fetch |=> bit_idx_r == 3'h7) // RULE9
      else $error("burst not msb first");
   chk_clear_all: assert property (@(posedge core_clk) disable iff (!resetn)
      clr_prox && clr_light && !prox_irq_event && !light_irq_event
      |=> !prox_irq && !light_irq) // RULE21
      else $error("clear all left irq set");
   chk_burst_clear: assert property (@(posedge core_clk) disable iff (!resetn)
      clr_burst && !burst_end |=> !burst_irq) // RULE22
      else $error("burst irq not cleared");
   chk_gesture_start: assert property (@(posedge core_clk) disable iff (!resetn)
      !gesture_on |=> !gesture_start) // RULE12
      else $error("gesture started without enable");
   chk_wait_follow: assert property (@(posedge core_clk) disable iff (!resetn)
      reg_wr && hit_enable |=> ##1 wait_timer_run == $past(reg_wdata[EN_WAIT], 2)) // RULE15
      else $error("wait timer not following enable");

   cov_burst_done: cover property (@(posedge core_clk) disable iff (!resetn) burst_end);
   cov_gesture_wr: cover property (@(posedge core_clk) disable iff (!resetn) gest_store);
   cov_ram_read: cover property (@(posedge core_clk) disable iff (!resetn) rd_ram_q);
   cov_burst_start: cover property (@(posedge core_clk) disable iff (!resetn) start_burst);
   cov_force_hit: cover property (@(posedge core_clk) disable iff (!resetn) force_hit);
endmodule // pattern_ctrl

// *** bench/host_model.sv ***
module host_model (
   input wire logic core_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h5A;
      reg_wdata = 8'hA5;
   end

   // a released bus shows the inverse of its last value, never a stale copy
   task automatic release_bus();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask

   // one byte per strobe; sequential transfers are repeated single accesses
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      release_bus();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      release_bus();
      // bounded wait: the answer is due two edges after the strobe
      for (int i = 0; i < 4; i++) begin
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            break;
         end
         @(negedge core_clk);
      end
   endtask
endmodule // host_model

// *** bench/test_pattern_ctrl.sv ***
module test_pattern_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   import pattern_ctrl_pkg::*;

   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic bus_active = 1'b0;
   logic gesture_mode_select = 1'b0;
   logic prox_pulse = 1'b0;
   logic prox_irq_event = 1'b0;
   logic light_irq_event = 1'b0;
   logic gesture_wr = 1'b0;
   logic [7:0] gesture_data = 8'h3C;
   logic [7:0] gq [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   logic reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic led_drive_pin, pattern_busy_flag, oscillator_run, wait_timer_run;
   logic proximity_run, light_run, gesture_start, prox_irq, light_irq;
   logic burst_irq, irq_force_pulse;
   int n_mismatch = 0;
   int checked = 0;

   always #50 core_clk = ~core_clk;

   host_model u_host_model (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   pattern_ctrl u_pattern_ctrl (.core_clk(core_clk), .resetn(resetn),
      .bus_active(bus_active), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .gesture_mode_select(gesture_mode_select), .prox_pulse(prox_pulse),
      .prox_irq_event(prox_irq_event), .light_irq_event(light_irq_event),
      .gesture_wr(gesture_wr), .gesture_data(gesture_data), .gesture_queue_n(gq[0]),
      .gesture_queue_s(gq[1]), .gesture_queue_w(gq[2]), .gesture_queue_e(gq[3]),
      .led_drive_pin(led_drive_pin), .pattern_busy_flag(pattern_busy_flag),
      .oscillator_run(oscillator_run), .wait_timer_run(wait_timer_run),
      .proximity_run(proximity_run), .light_run(light_run),
      .gesture_start(gesture_start), .prox_irq(prox_irq), .light_irq(light_irq),
      .burst_irq(burst_irq), .irq_force_pulse(irq_force_pulse));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host_model.rd(a, d);
      chk($sformatf("read %h", a), exp, d);
   endtask

   task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
      u_host_model.wr(a, d);
      repeat (2) @(negedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("outputs", 8'h00, {oscillator_run, wait_timer_run, proximity_run, light_run,
         gesture_start, prox_irq, light_irq, burst_irq});
      rd_chk(FUNCTION_ENABLE_ADDR, 8'h00);
      foreach (gq[i])
         rd_chk(8'hAA + 8'(i), 8'h00);
   endtask

   task automatic t_power();
      u_host_model.wr(8'h05, 8'hA5);
      rd_chk(8'h05, 8'h00);
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h01);
      chk("osc on", 8'h01, {7'h0, oscillator_run});
      u_host_model.wr(8'h00, 8'hA5);
      u_host_model.wr(8'h01, 8'h5A);
      u_host_model.wr(PATTERN_RAM_LAST, 8'hC3);
      rd_chk(8'h00, 8'hA5);
      rd_chk(8'h01, 8'h5A);
      rd_chk(PATTERN_RAM_LAST, 8'hC3);
      for (int i = 1; i < 4; i++) begin
         wr_settle(FUNCTION_ENABLE_ADDR, 8'h01 | (8'h01 << i));
         chk("run bits", 8'h01 << i, {4'h0, wait_timer_run, proximity_run, light_run,
            1'b0});
      end
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h00);
      chk("osc off", 8'h00, {7'h0, oscillator_run});
      bus_active = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("osc bus", 8'h01, {7'h0, oscillator_run});
      bus_active = 1'b0;
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h01);
      rd_chk(8'h00, 8'hA5);
   endtask

   task automatic t_burst();
      logic [7:0] pat = 8'hA5;
      for (int a = SHARED_FIRST; a <= SHARED_LAST; a++) begin
         if (8'(a) != BIT_TIME_ADDR && 8'(a) != SYMBOL_LENGTH_ADDR) begin
            u_host_model.wr(8'(a), 8'h00);
         end
      end
      // timing is programmed before the burst is enabled
      u_host_model.wr(BIT_TIME_ADDR, 8'h03);
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h01);
      prox_pulse = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("pin prox", 8'h01, {7'h0, led_drive_pin});
      u_host_model.wr(FUNCTION_ENABLE_ADDR, 8'h81);
      u_host_model.wr(SYMBOL_LENGTH_ADDR, 8'h01);
      @(negedge core_clk);
      chk("busy", 8'h01, {7'h0, pattern_busy_flag});
      repeat (3) @(negedge core_clk);
      // sample mid-bit: each bit holds four cycles, prox_pulse stays high throughout
      for (int k = 7; k >= 0; k--) begin
         chk($sformatf("pin bit %0d", k), {7'h0, pat[k]}, {7'h0, led_drive_pin});
         repeat (4) @(negedge core_clk);
      end
      for (int i = 0; i < 20 && pattern_busy_flag !== 1'b0; i++)
         @(negedge core_clk);
      chk("burst irq", 8'h01, {7'h0, burst_irq});
      rd_chk(BURST_IRQ_CLEAR_ADDR, 8'h00);
      chk("burst clr", 8'h00, {7'h0, burst_irq});
      u_host_model.wr(SYMBOL_LENGTH_ADDR, 8'h01);
      u_host_model.wr(8'h00, 8'h00);
      rd_chk(8'h00, 8'h00);
      for (int i = 0; i < 60 && pattern_busy_flag !== 1'b0; i++)
         @(negedge core_clk);
      prox_pulse = 1'b0;
      rd_chk(8'h00, 8'hA5);
   endtask

   task automatic t_irq();
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h01);
      prox_irq_event = 1'b1;
      light_irq_event = 1'b1;
      @(negedge core_clk);
      prox_irq_event = 1'b0;
      light_irq_event = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("irq masked", 8'h00, {6'h0, prox_irq, light_irq});
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h31);
      prox_irq_event = 1'b1;
      light_irq_event = 1'b1;
      @(negedge core_clk);
      prox_irq_event = 1'b0;
      light_irq_event = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("irq raised", 8'h03, {6'h0, prox_irq, light_irq});
      wr_settle(ALL_IRQ_CLEAR_ADDR, 8'h00);
      chk("irq cleared", 8'h00, {6'h0, prox_irq, light_irq});
      u_host_model.wr(IRQ_FORCE_ADDR, 8'h01);
      chk("force pulse", 8'h01, {7'h0, irq_force_pulse});
      @(negedge core_clk);
      chk("force end", 8'h00, {7'h0, irq_force_pulse});
   endtask

   task automatic t_gesture();
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h45);
      gesture_mode_select = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("gesture start", 8'h01, {7'h0, gesture_start});
      gesture_wr = 1'b1;
      @(negedge core_clk);
      gesture_wr = 1'b0;
      gesture_mode_select = 1'b0;
      // host writes are refused while the gesture engine owns the memory
      u_host_model.wr(8'h01, 8'h77);
      wr_settle(FUNCTION_ENABLE_ADDR, 8'h01);
      chk("gesture stop", 8'h00, {7'h0, gesture_start});
      rd_chk(8'h00, 8'h3C);
      rd_chk(8'h01, 8'h5A);
      foreach (gq[i])
         rd_chk(GESTURE_NORTH_QUEUE_ADDR + 8'(i), gq[i]);
      rd_chk(8'h90, UNMAPPED_READ);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      t_reset();
      t_power();
      t_burst();
      t_irq();
      t_gesture();
      end_of_test();
   end
endmodule // test_pattern_ctrl
